// ### verilog/twcsp_consts.svh
`ifndef TWCSP_CONSTS_SVH
`define TWCSP_CONSTS_SVH

// ----------------------------------------
// link timing
// ----------------------------------------
`define TWCSP_MCLK_PERIOD_NS 4
`define TWCSP_SCL_MAX_KHZ    100
`define TWCSP_SCL_PERIOD_NS  (1000000 / `TWCSP_SCL_MAX_KHZ)
`define TWCSP_SCL_PERIOD_CYC (`TWCSP_SCL_PERIOD_NS / `TWCSP_MCLK_PERIOD_NS)

// ----------------------------------------
// byte framing (bit counter values)
// ----------------------------------------
`define TWCSP_LAST_BIT 4'h7
`define TWCSP_ACK_SLOT 4'h8
`define TWCSP_CNT_ZERO 4'h0
`define TWCSP_CNT_ONE  4'h1

// ----------------------------------------
// register store
// ----------------------------------------
`define TWCSP_MEM_DEPTH   16
`define TWCSP_FAULT_IDX   4'hC
`define TWCSP_MEM_RESET   8'h00
`define TWCSP_ADDR_ONE    4'h1

`endif

// ### verilog/twcsp_pkg.sv
package twcsp_pkg;

  typedef enum logic [2:0] {
    TWCSP_ST_ADDR   = 3'b000,
    TWCSP_ST_WORD   = 3'b001,
    TWCSP_ST_WDATA  = 3'b010,
    TWCSP_ST_RDATA  = 3'b011,
    TWCSP_ST_IGNORE = 3'b100
  } twcsp_state_t;

  typedef logic [7:0] twcsp_byte_t;
  typedef logic [3:0] twcsp_addr_t;

endpackage

// ### verilog/twcsp_link_if.sv
`timescale 1ns/1ps
interface twcsp_link_if;
  logic                linkRst;
  logic [3:0]          typeCode;
  twcsp_pkg::twcsp_byte_t txByte;
  logic                driveLow;
  logic                rxTgl;
  logic                rdTgl;
  twcsp_pkg::twcsp_byte_t rxByte;
  logic                rxIsAddr;

  modport link (
    input  linkRst,
    input  typeCode,
    input  txByte,
    output driveLow,
    output rxTgl,
    output rdTgl,
    output rxByte,
    output rxIsAddr
  );

  modport core (
    output linkRst,
    output typeCode,
    output txByte,
    input  driveLow,
    input  rxTgl,
    input  rdTgl,
    input  rxByte,
    input  rxIsAddr
  );
endinterface

// ### verilog/twcsp_link.sv
`timescale 1ns/1ps
`include "twcsp_consts.svh"
module twcsp_link (
  input wire logic    sclClk,
  input wire logic    sdaIn,
  twcsp_link_if.link  lnk
);

  twcsp_pkg::twcsp_state_t st_r;
  logic [3:0]              cnt_r;
  logic [7:0]              sh_r;
  logic [7:0]              tx_r;
  logic [7:0]              byteNow;

  assign byteNow = {sh_r[6:0], sdaIn};

  // ----------------------------------------
  // bit counter and input shifter
  // ----------------------------------------
  // reset pulses on every start and stop, so each frame opens clean
  always_ff @(posedge sclClk or posedge lnk.linkRst) begin
    if (lnk.linkRst) begin
      cnt_r <= `TWCSP_CNT_ZERO;
    end else if (cnt_r == `TWCSP_ACK_SLOT) begin
      cnt_r <= `TWCSP_CNT_ZERO; // R7
    end else begin
      cnt_r <= cnt_r + `TWCSP_CNT_ONE;
    end
  end

  always_ff @(posedge sclClk or posedge lnk.linkRst) begin
    if (lnk.linkRst) begin
      sh_r <= 8'h00;
    end else begin
      sh_r <= byteNow;
    end
  end

  // ----------------------------------------
  // framing, acknowledge and read data
  // ----------------------------------------
  // driveLow is the level wanted during the next scl low phase
  always_ff @(posedge sclClk or posedge lnk.linkRst) begin
    if (lnk.linkRst) begin
      st_r         <= twcsp_pkg::TWCSP_ST_ADDR;
      lnk.driveLow <= 1'b0;
      tx_r         <= 8'h00;
      lnk.rxTgl    <= 1'b0;
      lnk.rdTgl    <= 1'b0;
      lnk.rxByte   <= 8'h00;
      lnk.rxIsAddr <= 1'b0;
    end else begin
      case (st_r)
        twcsp_pkg::TWCSP_ST_ADDR: begin
          if (cnt_r == `TWCSP_LAST_BIT) begin
            if (byteNow[7:4] == lnk.typeCode) begin // R14
              lnk.driveLow <= 1'b1; // R15
            end else begin
              st_r         <= twcsp_pkg::TWCSP_ST_IGNORE; // R18
              lnk.driveLow <= 1'b0;
            end
          end else if (cnt_r == `TWCSP_ACK_SLOT) begin
            if (sh_r[0]) begin
              st_r         <= twcsp_pkg::TWCSP_ST_RDATA; // R13
              tx_r         <= lnk.txByte;
              lnk.driveLow <= ~lnk.txByte[7];
            end else begin
              st_r         <= twcsp_pkg::TWCSP_ST_WORD;
              lnk.driveLow <= 1'b0;
            end
          end
        end
        twcsp_pkg::TWCSP_ST_WORD, twcsp_pkg::TWCSP_ST_WDATA: begin
          if (cnt_r == `TWCSP_LAST_BIT) begin
            lnk.driveLow <= 1'b1; // R17
            lnk.rxByte   <= byteNow;
            lnk.rxIsAddr <= (st_r == twcsp_pkg::TWCSP_ST_WORD);
            lnk.rxTgl    <= ~lnk.rxTgl;
          end else if (cnt_r == `TWCSP_ACK_SLOT) begin
            lnk.driveLow <= 1'b0; // R9
            st_r         <= twcsp_pkg::TWCSP_ST_WDATA;
          end
        end
        twcsp_pkg::TWCSP_ST_RDATA: begin
          if (cnt_r < `TWCSP_LAST_BIT) begin
            lnk.driveLow <= ~tx_r[6];
            tx_r         <= {tx_r[6:0], 1'b0};
          end else if (cnt_r == `TWCSP_LAST_BIT) begin
            lnk.driveLow <= 1'b0; // R8
            lnk.rdTgl    <= ~lnk.rdTgl;
          end else if (!sdaIn) begin
            tx_r         <= lnk.txByte; // R16
            lnk.driveLow <= ~lnk.txByte[7];
          end else begin
            st_r         <= twcsp_pkg::TWCSP_ST_IGNORE; // R11
            lnk.driveLow <= 1'b0;
          end
        end
        default: begin
          lnk.driveLow <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### verilog/twcsp_top.sv
`timescale 1ns/1ps
`include "twcsp_consts.svh"
// Notes on behaviour
// R1: scl runs up to 100 kHz from the master; sampling margins sized for that.
// R2: idle bus has both lines high; slave releases sda when not busy.
// R3: master starts a transfer only with both lines high.
// R4: sda falling while scl high is taken as start.
// R5: sda rising while scl high is taken as stop.
// R6: pure slave; never drives scl and never starts anything.
// R7: traffic is eight-bit units each followed by one acknowledge slot.
// R8: sender releases sda after eight bits.
// R9: receiver pulls sda low during ninth clock to acknowledge.
// R10: master leaves sda high after last read byte (no acknowledge).
// R11: on no acknowledge the slave stops sending and keeps sda released.
// R12: master issues stop on the clock pulse after no acknowledge.
// R13: master reads and writes the configuration store and fault latch.
// R14: first byte is seven-bit address plus direction, one means read.
// R15: address acknowledged only after start and matching device type code.
// R16: during read, next byte is sent whenever master acknowledges.
// R17: during write, every received byte is acknowledged until stop.
// R18: address mismatch leaves sda released until the next start.
// R19: stop abandons any transfer, releases sda and returns to idle.
module twcsp_top #(
  parameter logic [3:0] DEV_TYPE_CODE = 4'h6 // arbitrary value
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       sclClk,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       faultIn,
  output logic            memWrStrobe,
  output logic [3:0]      memWrAddr,
  output logic [7:0]      memWrData,
  output logic            faultLatch,
  output logic            busBusy
);

  twcsp_link_if lnk ();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclS1_r;
  logic sclS2_r;
  logic sclS3_r;
  logic sdaS1_r;
  logic sdaS2_r;
  logic sdaS3_r;
  logic startDet;
  logic stopDet;
  logic sclFall;

  // 4 ns sampling against a 10 us bit time leaves wide margin
  always_ff @(posedge mclk) begin
    if (reset) begin
      sclS1_r <= 1'b1;
      sclS2_r <= 1'b1;
      sclS3_r <= 1'b1;
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
      sdaS3_r <= 1'b1;
    end else begin
      sclS1_r <= sclIn; // R1
      sclS2_r <= sclS1_r;
      sclS3_r <= sclS2_r;
      sdaS1_r <= sdaIn;
      sdaS2_r <= sdaS1_r;
      sdaS3_r <= sdaS2_r;
    end
  end

  assign startDet = sclS2_r && sclS3_r && sdaS3_r && !sdaS2_r; // R4
  assign stopDet  = sclS2_r && sclS3_r && !sdaS3_r && sdaS2_r; // R5
  assign sclFall  = sclS3_r && !sclS2_r;

  // ----------------------------------------
  // bus state and link reset
  // ----------------------------------------
  logic busy_r;
  logic linkRst_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else if (stopDet) begin
      busy_r <= 1'b0; // R19
    end else if (startDet) begin
      busy_r <= 1'b1;
    end
  end

  // pulses the link-side async reset; scl is high then, so no edge is near
  always_ff @(posedge mclk) begin
    if (reset) begin
      linkRst_r <= 1'b1;
    end else begin
      linkRst_r <= startDet || stopDet; // R19
    end
  end

  assign busBusy      = busy_r;
  assign lnk.linkRst  = linkRst_r;
  assign lnk.typeCode = DEV_TYPE_CODE;

  // ----------------------------------------
  // crossings from the link domain
  // ----------------------------------------
  logic drvS1_r;
  logic drvS2_r;
  logic rxT1_r;
  logic rxT2_r;
  logic rxT3_r;
  logic rdT1_r;
  logic rdT2_r;
  logic rdT3_r;
  logic rxEvt;
  logic rdEvt;

  always_ff @(posedge mclk) begin
    if (reset) begin
      drvS1_r <= 1'b0;
      drvS2_r <= 1'b0;
      rxT1_r  <= 1'b0;
      rxT2_r  <= 1'b0;
      rxT3_r  <= 1'b0;
      rdT1_r  <= 1'b0;
      rdT2_r  <= 1'b0;
      rdT3_r  <= 1'b0;
    end else begin
      drvS1_r <= lnk.driveLow;
      drvS2_r <= drvS1_r;
      // link reset zeroes both toggles; clearing the copies hides that false edge
      rxT1_r  <= lnk.rxTgl;
      rxT2_r  <= rxT1_r && !linkRst_r; // R17 R19
      rxT3_r  <= rxT2_r && !linkRst_r;
      rdT1_r  <= lnk.rdTgl;
      rdT2_r  <= rdT1_r && !linkRst_r; // R16 R19
      rdT3_r  <= rdT2_r && !linkRst_r;
    end
  end

  // rxByte and rxIsAddr are held for a whole byte time after the toggle
  assign rxEvt = busy_r && (rxT2_r ^ rxT3_r);
  assign rdEvt = busy_r && (rdT2_r ^ rdT3_r);

  // ----------------------------------------
  // sda driver (open drain)
  // ----------------------------------------
  // changes only just after scl falls, keeping sda stable while scl is high
  always_ff @(posedge mclk) begin
    if (reset) begin
      sdaOe <= 1'b0;
    end else if (!busy_r || startDet || stopDet) begin
      sdaOe <= 1'b0; // R2 R19
    end else if (sclFall) begin
      sdaOe <= drvS2_r; // R9
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0; // R6
    end
  end

  // ----------------------------------------
  // address counter
  // ----------------------------------------
  twcsp_pkg::twcsp_addr_t addr_r;
  logic                   wrHit;

  assign wrHit = rxEvt && !lnk.rxIsAddr;

  // rolls over at the top of the store
  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_r <= 4'h0;
    end else if (rxEvt && lnk.rxIsAddr) begin
      addr_r <= lnk.rxByte[3:0];
    end else if (wrHit || rdEvt) begin
      addr_r <= addr_r + `TWCSP_ADDR_ONE; // R16 R17
    end
  end

  // ----------------------------------------
  // configuration store and fault latch
  // ----------------------------------------
  logic [7:0] mem_r [`TWCSP_MEM_DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < `TWCSP_MEM_DEPTH; gi++) begin : g_mem
      if (gi == `TWCSP_FAULT_IDX) begin : g_fault
        // hardware set wins over a software clear in the same cycle
        always_ff @(posedge mclk) begin
          if (reset) begin
            mem_r[gi] <= `TWCSP_MEM_RESET;
          end else if (wrHit && addr_r == 4'(gi)) begin
            mem_r[gi] <= {lnk.rxByte[7:1], lnk.rxByte[0] | faultIn}; // R13
          end else if (faultIn) begin
            mem_r[gi][0] <= 1'b1;
          end
        end
      end else begin : g_cfg
        always_ff @(posedge mclk) begin
          if (reset) begin
            mem_r[gi] <= `TWCSP_MEM_RESET;
          end else if (wrHit && addr_r == 4'(gi)) begin
            mem_r[gi] <= lnk.rxByte; // R13
          end
        end
      end
    end
  endgenerate

  // read data settles within cycles; link samples it microseconds later
  twcsp_pkg::twcsp_byte_t txByte_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      txByte_r <= 8'h00;
    end else begin
      txByte_r <= mem_r[addr_r]; // R13
    end
  end

  assign lnk.txByte = txByte_r;

  // ----------------------------------------
  // user-side outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      memWrStrobe <= 1'b0;
      memWrAddr   <= 4'h0;
      memWrData   <= 8'h00;
      faultLatch  <= 1'b0;
    end else begin
      memWrStrobe <= wrHit;
      faultLatch  <= mem_r[`TWCSP_FAULT_IDX][0];
      if (wrHit) begin
        memWrAddr <= addr_r;
        memWrData <= lnk.rxByte;
      end
    end
  end

  // ----------------------------------------
  // link-side engine
  // ----------------------------------------
  twcsp_link u_link (
    .sclClk (sclClk),
    .sdaIn  (sdaIn),
    .lnk    (lnk.link)
  );

endmodule

// ### bench/twcsp_top_asserts.sv
`timescale 1ns/1ps
module twcsp_top_asserts (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       sclClk,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       faultIn,
  input wire logic       memWrStrobe,
  input wire logic [3:0] memWrAddr,
  input wire logic [7:0] memWrData,
  input wire logic       faultLatch,
  input wire logic       busBusy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence startSeen;
    sclIn && $fell(sdaIn);
  endsequence

  sequence stopSeen;
    sclIn && $rose(sdaIn);
  endsequence

  chk_out_low: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  chk_start_busy: assert property (startSeen |-> ##[1:6] busBusy)
    else $error("start not seen");
  chk_stop_idle: assert property (stopSeen |-> ##[1:6] !busBusy)
    else $error("stop not seen");
  chk_idle_release: assert property ((!busBusy)[*8] |-> !sdaOe)
    else $error("data line held on idle bus");
  chk_oe_rise: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("pull started with clock high");
  // a change while the clock is high would read as a false start or stop
  chk_high_stable: assert property (sclIn && $past(sclIn) && busBusy |-> $stable(sdaOe))
    else $error("data line moved while clock high");
  chk_strobe_once: assert property (memWrStrobe |=> !memWrStrobe)
    else $error("write strobe longer than one cycle");
  chk_strobe_bus: assert property (memWrStrobe |-> busBusy && sclIn && !sdaOe)
    else $error("write strobe out of place");
  chk_fault_set: assert property (faultIn |-> ##[1:3] faultLatch)
    else $error("fault latch not set");
  chk_start_quiet: assert property (startSeen |=> (!memWrStrobe)[*8])
    else $error("write strobe right after start");
endmodule
bind twcsp_top twcsp_top_asserts u_twcsp_top_asserts (
  .mclk(mclk), .reset(reset), .sclClk(sclClk), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .faultIn(faultIn), .memWrStrobe(memWrStrobe),
  .memWrAddr(memWrAddr), .memWrData(memWrData), .faultLatch(faultLatch), .busBusy(busBusy)
);

// ### bench/twcsp_master_model.sv
`timescale 1ns/1ps
module twcsp_master_model #(
  parameter int HALF = 1250
) (
  input  wire logic mclk,
  input  wire logic sdaIn,
  output logic      sclOut,
  output logic      sdaLow
);
  localparam int QTR = HALF / 2;

  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic waitC(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // data moves only while the clock is low
  task automatic bitX(input logic b, output logic r);
    waitC(QTR);
    sdaLow = !b;
    waitC(QTR);
    sclOut = 1'b1;
    waitC(QTR);
    r = sdaIn;
    waitC(QTR);
    sclOut = 1'b0;
  endtask

  task automatic startC();
    sdaLow = 1'b0;
    waitC(QTR);
    sclOut = 1'b1;
    waitC(HALF);
    sdaLow = 1'b1;
    waitC(HALF);
    sclOut = 1'b0;
  endtask

  task automatic stopC();
    waitC(QTR);
    sdaLow = 1'b1;
    waitC(QTR);
    sclOut = 1'b1;
    waitC(HALF);
    sdaLow = 1'b0;
    waitC(HALF);
  endtask

  task automatic wrB(input twcsp_pkg::twcsp_byte_t d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitX(d[i], r);
    bitX(1'b1, r);
    ack = !r;
  endtask

  task automatic rdB(input logic ack, output twcsp_pkg::twcsp_byte_t d);
    logic r;
    for (int i = 7; i >= 0; i--) bitX(1'b1, d[i]);
    bitX(!ack, r);
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] TC = 4'h6; // arbitrary value
  localparam int LIMIT = 90000;
  logic                   mclk;
  logic                   reset = 1'b1;
  logic                   faultIn = 1'b0;
  wire                    scl;
  wire                    sdaLow;
  wire                    sda;
  logic                   sdaOut;
  logic                   sdaOe;
  logic                   memWrStrobe;
  logic [3:0]             memWrAddr;
  logic [7:0]             memWrData;
  logic                   faultLatch;
  logic                   busBusy;
  logic [11:0]            expQ[$];
  int                     mismatches = 0;
  int                     checks = 0;
  int                     cycles = 0;
  logic                   bitR;
  twcsp_pkg::twcsp_byte_t d0;
  twcsp_pkg::twcsp_byte_t d1;

  assign sda = !(sdaLow || sdaOe);

  twcsp_top #(.DEV_TYPE_CODE(TC)) u_twcsp_top (
    .mclk(mclk), .reset(reset), .sclClk(scl), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .faultIn(faultIn), .memWrStrobe(memWrStrobe), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .faultLatch(faultLatch), .busBusy(busBusy)
  );
  // quicker clock than 100 kHz keeps the run short; still 1 us phases
  twcsp_master_model #(.HALF(250)) u_twcsp_master_model (
    .mclk(mclk), .sdaIn(sda), .sclOut(scl), .sdaLow(sdaLow)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic twcsp_pkg::twcsp_byte_t ab(input logic [3:0] code, input logic rw);
    return {code, 3'($urandom), rw};
  endfunction

  task automatic wr(input twcsp_pkg::twcsp_byte_t d, input logic expAck);
    logic ack;
    u_twcsp_master_model.wrB(d, ack);
    chk("ack", {11'h0, expAck}, {11'h0, ack});
  endtask

  task automatic rd(input logic ack, input twcsp_pkg::twcsp_byte_t exp);
    twcsp_pkg::twcsp_byte_t got;
    u_twcsp_master_model.rdB(ack, got);
    chk("rdata", {4'h0, exp}, {4'h0, got});
  endtask

  // an empty queue expects nothing, so any stray strobe mismatches
  always @(negedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
    if (memWrStrobe === 1'b1) begin
      chk("memWr", (expQ.size() > 0) ? expQ.pop_front() : 12'hXXX, {memWrAddr, memWrData});
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2e935032));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    // write across the top of the store, counter wraps
    u_twcsp_master_model.startC();
    wr(ab(TC, 1'b0), 1'b1);
    wr(8'h0F, 1'b1);
    expQ.push_back({4'hF, d0});
    wr(d0, 1'b1);
    expQ.push_back({4'h0, d1});
    wr(d1, 1'b1);
    u_twcsp_master_model.stopC();
    // stop in mid-byte
    u_twcsp_master_model.startC();
    wr(ab(TC, 1'b0), 1'b1);
    for (int i = 0; i < 4; i++) u_twcsp_master_model.bitX(1'b0, bitR);
    u_twcsp_master_model.stopC();
    chk("busy", 12'h0, {11'h0, busBusy});
    chk("oe", 12'h0, {11'h0, sdaOe});
    // foreign type code is ignored
    u_twcsp_master_model.startC();
    wr(ab(TC ^ 4'h1, 1'b0), 1'b0);
    wr(8'h5A, 1'b0);
    u_twcsp_master_model.stopC();
    faultIn = 1'b1;
    repeat (3) @(negedge mclk);
    faultIn = 1'b0;
    repeat (4) @(negedge mclk);
    chk("fault", 12'h1, {11'h0, faultLatch});
    // random read back through the wrap, repeated start
    u_twcsp_master_model.startC();
    wr(ab(TC, 1'b0), 1'b1);
    wr(8'h0F, 1'b1);
    u_twcsp_master_model.startC();
    wr(ab(TC, 1'b1), 1'b1);
    rd(1'b1, d0);
    rd(1'b1, d1);
    rd(1'b0, 8'h00);
    repeat (10) @(negedge mclk);
    chk("oe", 12'h0, {11'h0, sdaOe});
    u_twcsp_master_model.stopC();
    chk("busy", 12'h0, {11'h0, busBusy});
    repeat (100) @(negedge mclk);
    give_verdict();
  end
endmodule
